/* File: core/rcs_map.svh */
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// register byte offsets on the wishbone slave
`define RCS_OFF_STATUS   5'h0_0
`define RCS_OFF_CFG      5'h0_4
`define RCS_OFF_WDOG     5'h0_8
`define RCS_OFF_APPLIED  5'h0_C

// status field positions
`define RCS_ST_STATE_LSB 0
`define RCS_ST_WRITTEN   4
`define RCS_ST_LATE      5
`define RCS_ST_STRAP_LSB 16

// sequence counts in input-clock cycles
`define RCS_POR_STRETCH_CYC 16'h0_400
`define RCS_HARD_REL_CYC    16'h0_200
`define RCS_SOFT_REL_CYC    16'h0_203
`define RCS_EXT_SOFT_CYC    16'h0_010

// reset values
`define RCS_CFG_DEFAULT   32'h0000_0000
`define RCS_WDOG_RELOAD   16'hFFFF

`endif

/* File: core/rcs_pkg.sv */
package rcs_pkg;

	typedef enum logic [2:0] {
		ST_POR,
		ST_STRETCH,
		ST_PLL,
		ST_HARD,
		ST_SOFT,
		ST_RUN
	} rcs_state_e;

	typedef logic [13:0] rcs_strap_t;

endpackage : rcs_pkg

/* File: core/rcs_top.sv */
// What this block does
// - config arrives by host port or system bus
// - bus role master or slave from straps
// - slave with no write uses default word
// - capture fourteen straps at power-on release
// - stretch internal power-on reset 1024 cycles
// - pll locks within 6400 reference cycles
// - hard reset released 512 cycles after lock
// - soft reset released 515 cycles after lock
// - soft reset held while hard reset held
// - external soft reset only when not resetting
// - host write in power-on only, bus also hard
// - watchdog reaching zero starts hard reset
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"

module rcs_top
	import rcs_pkg::*;
#(
	parameter int PLL_LOCK_REF_CYC = 6400,
	parameter int PLL_REF_DIV      = 1
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        power_on_reset_in_n_i,
	input  wire logic        config_source_strap_i,
	input  wire logic        config_slave_strap_i,
	input  wire logic        host_port_sync_strap_i,
	input  wire logic        host_port_width_strap_i,
	input  wire logic [3:0]  device_select_id_i,
	input  wire logic [2:0]  boot_source_strap_i,
	input  wire logic        watchdog_enable_strap_i,
	input  wire logic [1:0]  clock_mode_strap_i,
	input  wire logic        system_pll_lock_i,
	input  wire logic        host_cfg_wr_i,
	input  wire logic [31:0] host_cfg_data_i,
	input  wire logic        bus_cfg_valid_i,
	input  wire logic [31:0] bus_cfg_data_i,
	input  wire logic        hard_reset_line_n_i,
	output logic             hard_reset_line_n_o,
	output logic             hard_reset_line_n_oe_o,
	input  wire logic        soft_reset_line_n_i,
	output logic             soft_reset_line_n_o,
	output logic             soft_reset_line_n_oe_o,
	output logic             internal_por_o,
	output logic             system_pll_rst_o,
	output logic             pll_lock_late_o,
	output logic      [31:0] cfg_word_o,
	output logic      [13:0] straps_o
);

	localparam int PLL_LIMIT = PLL_LOCK_REF_CYC * PLL_REF_DIV;

	////////////////////////////////////////////////////////////////////////
	// state

	rcs_state_e  state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic        por_n_q, por_n_d;
	logic        por_phase_q, por_phase_d;
	rcs_strap_t  strap_q, strap_d;
	logic [31:0] cfg_q, cfg_d;
	logic        written_q, written_d;
	logic [31:0] applied_q, applied_d;
	logic        late_q, late_d;
	logic [15:0] wd_q, wd_d;
	logic [15:0] wd_rl_q, wd_rl_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        hard_drv_q, hard_drv_d;
	logic        soft_drv_q, soft_drv_d;

	logic        wb_req;
	logic        wb_wr;
	logic        bus_path;
	logic        bus_master;
	logic        cfg_window;

	assign wb_req     = wb_cyc_i & wb_stb_i & ~ack_q;
	// a write lands on the edge where the master sees ack high
	assign wb_wr      = wb_cyc_i & wb_stb_i & ack_q & wb_we_i
			& (&wb_sel_i);
	assign bus_path   = strap_q[13];
	assign bus_master = bus_path & ~strap_q[12];
	assign cfg_window = por_phase_q ? 1'b1
			: (bus_path && state_q == ST_HARD);

	////////////////////////////////////////////////////////////////////////
	// sequencer and config capture

	always_comb
	begin
		state_d     = state_q;
		cnt_d       = cnt_q + 16'h0_001;
		por_n_d     = power_on_reset_in_n_i;
		por_phase_d = por_phase_q;
		strap_d     = strap_q;
		cfg_d       = cfg_q;
		written_d   = written_q;
		applied_d   = applied_q;
		late_d      = late_q;
		wd_d        = wd_q;
		wd_rl_d     = wd_rl_q;
		hard_drv_d  = hard_drv_q;
		soft_drv_d  = soft_drv_q;

		// config word writes, host port or bus
		if (cfg_window)
		begin
			if (!bus_path && por_phase_q && host_cfg_wr_i)
			begin
				cfg_d     = host_cfg_data_i;
				written_d = 1'b1;
			end
			else if (bus_master && bus_cfg_valid_i)
			begin
				cfg_d     = bus_cfg_data_i;
				written_d = 1'b1;
			end
			else if (bus_path && !bus_master && wb_wr
					&& wb_adr_i == `RCS_OFF_CFG)
			begin
				cfg_d     = wb_dat_i;
				written_d = 1'b1;
			end
		end

		case (state_q)
			ST_POR:
			begin
				hard_drv_d = 1'b1;
				soft_drv_d = 1'b1;
				cnt_d      = 16'h0_000;
				if (power_on_reset_in_n_i && !por_n_q)
				begin
					strap_d = {config_source_strap_i,
						config_slave_strap_i,
						host_port_sync_strap_i,
						host_port_width_strap_i,
						device_select_id_i,
						boot_source_strap_i,
						watchdog_enable_strap_i,
						clock_mode_strap_i};
					state_d = ST_STRETCH;
				end
			end
			ST_STRETCH:
			begin
				if (cnt_q == `RCS_POR_STRETCH_CYC - 16'h0_001)
				begin
					state_d = ST_PLL;
					cnt_d   = 16'h0_000;
				end
			end
			ST_PLL:
			begin
				if (cnt_q == PLL_LIMIT[15:0] && !system_pll_lock_i)
					late_d = 1'b1;
				if (system_pll_lock_i)
				begin
					state_d = ST_HARD;
					cnt_d   = 16'h0_000;
				end
			end
			ST_HARD:
			begin
				if (cnt_q == `RCS_HARD_REL_CYC - 16'h0_001)
				begin
					hard_drv_d = 1'b0;
					applied_d = written_q ? cfg_q
						: `RCS_CFG_DEFAULT;
					por_phase_d = 1'b0;
				end
				if (cnt_q == `RCS_SOFT_REL_CYC - 16'h0_001)
				begin
					soft_drv_d = 1'b0;
					state_d    = ST_RUN;
					wd_d       = wd_rl_q;
				end
			end
			ST_SOFT:
			begin
				if (cnt_q == `RCS_EXT_SOFT_CYC - 16'h0_001)
				begin
					soft_drv_d = 1'b0;
					state_d    = ST_RUN;
				end
			end
			default:
			begin
				cnt_d = 16'h0_000;
				if (strap_q[2] && wd_q != 16'h0_000)
					wd_d = wd_q - 16'h0_001;
				if (strap_q[2] && wd_q == 16'h0_000)
				begin
					state_d    = ST_HARD;
					hard_drv_d = 1'b1;
					soft_drv_d = 1'b1;
					written_d  = 1'b0;
				end
				else if (!soft_reset_line_n_i)
				begin
					state_d    = ST_SOFT;
					soft_drv_d = 1'b1;
				end
			end
		endcase

		// software reload wins over the running count
		if (wb_wr && wb_adr_i == `RCS_OFF_WDOG)
		begin
			wd_rl_d = wb_dat_i[15:0];
			wd_d    = wb_dat_i[15:0];
		end

		if (!power_on_reset_in_n_i)
		begin
			state_d     = ST_POR;
			por_phase_d = 1'b1;
			hard_drv_d  = 1'b1;
			soft_drv_d  = 1'b1;
			written_d   = 1'b0;
			late_d      = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q     <= ST_POR;
			cnt_q       <= 16'h0_000;
			por_n_q     <= 1'b1;
			por_phase_q <= 1'b1;
			strap_q     <= '0;
			cfg_q       <= `RCS_CFG_DEFAULT;
			written_q   <= 1'b0;
			applied_q   <= `RCS_CFG_DEFAULT;
			late_q      <= 1'b0;
			wd_q        <= `RCS_WDOG_RELOAD;
			wd_rl_q     <= `RCS_WDOG_RELOAD;
			hard_drv_q  <= 1'b1;
			soft_drv_q  <= 1'b1;
		end
		else
		begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			por_n_q     <= por_n_d;
			por_phase_q <= por_phase_d;
			strap_q     <= strap_d;
			cfg_q       <= cfg_d;
			written_q   <= written_d;
			applied_q   <= applied_d;
			late_q      <= late_d;
			wd_q        <= wd_d;
			wd_rl_q     <= wd_rl_d;
			hard_drv_q  <= hard_drv_d;
			soft_drv_q  <= soft_drv_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: one-wait-state ack, unmapped reads zero

	always_comb
	begin
		ack_d  = wb_req;
		rdat_d = 32'h0000_0000;
		if (wb_adr_i == `RCS_OFF_STATUS)
		begin
			rdat_d[`RCS_ST_STATE_LSB +: 3] = state_q;
			rdat_d[`RCS_ST_WRITTEN]        = written_q;
			rdat_d[`RCS_ST_LATE]           = late_q;
			rdat_d[`RCS_ST_STRAP_LSB +: 14] = strap_q;
		end
		else if (wb_adr_i == `RCS_OFF_CFG)
			rdat_d = cfg_q;
		else if (wb_adr_i == `RCS_OFF_WDOG)
			rdat_d = {16'h0_000, wd_q};
		else if (wb_adr_i == `RCS_OFF_APPLIED)
			rdat_d = applied_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// open-drain pins only ever pull low
	assign hard_reset_line_n_o    = 1'b0;
	assign hard_reset_line_n_oe_o = hard_drv_q;
	assign soft_reset_line_n_o    = 1'b0;
	assign soft_reset_line_n_oe_o = soft_drv_q | hard_drv_q;
	assign internal_por_o   = (state_q == ST_POR) || (state_q == ST_STRETCH);
	assign system_pll_rst_o = internal_por_o;
	assign pll_lock_late_o  = late_q;
	assign cfg_word_o       = applied_q;
	assign straps_o         = strap_q;

endmodule : rcs_top
`default_nettype wire

/* File: dv/rcs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_ack_o,
	input wire logic power_on_reset_in_n_i,
	input wire logic soft_reset_line_n_i,
	input wire logic hard_reset_line_n_oe_o,
	input wire logic soft_reset_line_n_oe_o,
	input wire logic internal_por_o,
	input wire logic system_pll_lock_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic h = hard_reset_line_n_oe_o;
	wire logic s = soft_reset_line_n_oe_o;
	wire logic p = power_on_reset_in_n_i;
	logic [10:0] sc_q;
	logic [9:0]  lc_q;
	////////////////////////////////////////////////////////////
	// stretch length and cycles since lock
	always_ff @(posedge clk_i)
	begin
		sc_q <= (p && internal_por_o && !rst_i)
			? sc_q + 11'h001 : 11'h000;
		if (!system_pll_lock_i || internal_por_o || rst_i)
			lc_q <= 10'h000;
		else if (lc_q != 10'h3FF)
			lc_q <= lc_q + 10'h001;
	end
	////////////////////////////////////////////////////////////
	property p_stretch; $fell(internal_por_o) |-> sc_q inside {[1023:1027]};
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("stretch length wrong");
	property p_por; !p |=> internal_por_o && h && s; endproperty
	a_por: assert property (p_por)
		else $error("power-on not driving resets");
	property p_lock; $fell(h) && lc_q < 1000 |-> lc_q inside {[512:516]};
	endproperty
	a_lock: assert property (p_lock)
		else $error("hard release not 512 after lock");
	property p_gap; $fell(h) |-> s [*3] ##1 !s; endproperty
	a_gap: assert property (p_gap)
		else $error("soft release not 3 after hard");
	property p_hold; h |-> s; endproperty
	a_hold: assert property (p_hold)
		else $error("soft free while hard held");
	property p_ext;
		!soft_reset_line_n_i && !s && !h && !internal_por_o && p |=> s;
	endproperty
	a_ext: assert property (p_ext)
		else $error("external soft reset missed");
	property p_ack; wb_cyc_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack)
		else $error("ack latency wrong");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse)
		else $error("ack longer than one cycle");
	c_por: cover property ($rose(p));
	c_run: cover property ($fell(s));
	c_ext: cover property (!soft_reset_line_n_i && !s && !h);
endmodule : rcs_checker
bind rcs_top rcs_checker i_rcs_checker (.clk_i, .rst_i, .wb_cyc_i,
	.wb_ack_o, .power_on_reset_in_n_i, .soft_reset_line_n_i,
	.hard_reset_line_n_oe_o, .soft_reset_line_n_oe_o, .internal_por_o,
	.system_pll_lock_i);
`default_nettype wire

/* File: dv/rcs_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_board_model (
	input wire logic       clk_i,
	input wire logic       por_go_i,
	input wire logic       pll_rst_i,
	input wire logic [7:0] lock_dly_i,
	output logic           por_n_o,
	output logic           lock_o
);
	logic [7:0] por_q = 8'h00;
	logic [7:0] lk_q = 8'h00;
	always @(posedge clk_i)
		por_q <= por_go_i ? 8'h14 : por_q - {7'h00, por_q != 8'h00};
	assign por_n_o = (por_q == 8'h00);
	always @(posedge clk_i)
		lk_q <= pll_rst_i ? 8'h00 : lk_q + {7'h00, lk_q != lock_dly_i};
	assign lock_o = !pll_rst_i && lk_q == lock_dly_i;
endmodule : rcs_board_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        go = 1'b0;
	logic        hwr = 1'b0;
	logic        bv = 1'b0;
	logic        ext_n = 1'b1;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] v;
	logic [31:0] rd;
	logic [13:0] st = 14'h0000;
	logic [13:0] s;
	logic [7:0]  dly = 8'h0A;
	logic        por_n, lock, ack, hoe, soe, hn, sn, prst, late;
	logic [31:0] dat, cfg;
	logic [13:0] str;
	int          err_total = 0;
	int          check_count = 0;
	wire logic   hw = hoe ? hn : 1'b1;
	wire logic   sw = (soe ? sn : 1'b1) & ext_n;
	always #4 clk_i = ~clk_i;
	rcs_top #(.PLL_LOCK_REF_CYC(50)) i_rcs_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(dat), .wb_ack_o(ack), .power_on_reset_in_n_i(por_n),
		.config_source_strap_i(st[13]), .config_slave_strap_i(st[12]),
		.host_port_sync_strap_i(st[11]), .host_port_width_strap_i(st[10]),
		.device_select_id_i(st[9:6]), .boot_source_strap_i(st[5:3]),
		.watchdog_enable_strap_i(st[2]), .clock_mode_strap_i(st[1:0]),
		.system_pll_lock_i(lock), .host_cfg_wr_i(hwr), .host_cfg_data_i(v),
		.bus_cfg_valid_i(bv), .bus_cfg_data_i(v), .hard_reset_line_n_i(hw),
		.hard_reset_line_n_o(hn), .hard_reset_line_n_oe_o(hoe),
		.soft_reset_line_n_i(sw), .soft_reset_line_n_o(sn),
		.soft_reset_line_n_oe_o(soe), .internal_por_o(),
		.system_pll_rst_o(prst), .pll_lock_late_o(late), .cfg_word_o(cfg),
		.straps_o(str));
	rcs_board_model i_rcs_board_model (.clk_i(clk_i), .por_go_i(go),
		.pll_rst_i(prst), .lock_dly_i(dly), .por_n_o(por_n), .lock_o(lock));
	////////////////////////////////////////////////////////////
	task results;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// wait for a reset line enable to reach a level
	task wt(input logic sel, input logic lvl, input int lim);
		int n;
		n = 0;
		check_count++;
		while ((sel ? hoe : soe) !== lvl)
		begin
			@(posedge clk_i);
			n++;
			if (n > lim)
			begin
				err_total++;
				results();
			end
		end
	endtask : wt
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do
		begin
			@(posedge clk_i);
			n++;
			if (n > 20)
			begin
				err_total++;
				results();
			end
		end while (ack !== 1'b1);
		rd = dat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task pulse(input logic h, input logic b);
		hwr <= h;
		bv <= b;
		@(posedge clk_i);
		hwr <= 1'b0;
		bv <= 1'b0;
	endtask : pulse
	// mode 3 and host word in hard reset fall back to default
	function automatic logic [31:0] exp_cfg(input int m, input logic hard,
		input logic [31:0] d);
		return (m == 3 || (hard && m == 1)) ? 32'h0000_0000 : d;
	endfunction : exp_cfg
	////////////////////////////////////////////////////////////
	initial
	begin
		v = $urandom(79656);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int m = 0; m < 4; m++)
		begin
			s = 14'($urandom);
			s[13:12] = (m == 1) ? 2'b00 : ((m == 2) ? 2'b10 : 2'b11);
			s[2] = 1'b1;
			v <= $urandom;
			dly <= (m == 1) ? 8'h50 : 8'h0A;
			st <= s;
			@(posedge clk_i);
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			repeat (30) @(posedge clk_i);
			if (m == 0)
				wb(1'b1, 5'h04, v);
			pulse(m == 1, m == 2);
			wt(1'b0, 1'b0, 6000);
			chk(cfg, exp_cfg(m, 1'b0, v));
			chk(str, s);
			chk(late, m == 1);
			st <= ~s;
			v <= ~v;
			pulse(1'b1, 1'b1);
			wb(1'b1, 5'h08, 32'h0000_0040);
			wt(1'b1, 1'b1, 200);
			if (m == 0)
				wb(1'b1, 5'h04, v);
			pulse(m == 1, m == 2);
			wt(1'b0, 1'b0, 1200);
			wb(1'b1, 5'h08, 32'h0000_FFFF);
			chk(cfg, exp_cfg(m, 1'b1, v));
			chk(str, s);
		end
		wb(1'b0, 5'h00, 32'h0000_0000);
		chk(rd & 32'h3FFF_0007, {2'b00, s, 13'h0000, 3'h5});
		wb(1'b1, 5'h10, 32'hFFFF_FFFF);
		wb(1'b0, 5'h10, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		ext_n <= 1'b0;
		@(posedge clk_i);
		ext_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(soe, 1'b1);
		wt(1'b0, 1'b0, 40);
		chk(str, s);
		results();
	end
endmodule : tb_top
`default_nettype wire
